/* File: rtl/bpm_pkg.sv */
// package for the dual bidirectional port block with pin sharing
// assumes a 32-bit AXI4-Lite register bus and a 50 MHz single clock
`default_nettype none
package bpm_pkg;
	// printed offsets are not all multiples of four: they are indices
	localparam logic [9:0] IDX_THIRD_DATA = 10'h007;
	localparam logic [9:0] IDX_FOURTH_DATA = 10'h008;
	localparam logic [9:0] IDX_THIRD_DIR = 10'h087;
	localparam logic [9:0] IDX_FOURTH_DIR = 10'h088;
	localparam logic [9:0] IDX_SEG_LOW = 10'h11c;
	localparam logic [9:0] IDX_SEG_MID = 10'h11d;
	// own control registers for peripheral claims, oscillator mode and bias inputs
	localparam logic [9:0] IDX_PERIPH_CTRL = 10'h120;
	localparam logic [9:0] IDX_OSC_MODE = 10'h121;
	localparam logic [9:0] IDX_BIAS_CTRL = 10'h122;
	localparam logic [7:0] DIR_RESET = 8'hff;
	localparam logic [7:0] SEG_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [1:0] OSC_RESET = 2'h0;
	// periph control field positions
	localparam int PC_TMR_GATE = 0;
	localparam int PC_TMR_CLK = 1;
	localparam int PC_SPI_DO = 2;
	localparam int PC_CCP = 3;
	localparam int PC_SERIAL = 4;
	localparam int PC_SER_DATA_OUT = 5;
	// oscillator modes
	localparam logic [1:0] OSC_INTERNAL = 2'h0;
	localparam logic [1:0] OSC_CRYSTAL = 2'h1;
	localparam logic [1:0] OSC_HIGH_SPEED = 2'h2;
	localparam logic [1:0] OSC_LOW_POWER = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {BPM_IDLE, BPM_WRESP, BPM_RRESP} bpm_state_t;
endpackage
`default_nettype wire

/* File: rtl/bpm_ports.sv */
// two 8-bit bidirectional ports with per-pin direction and pin sharing
// assumes pins sampled synchronously after external schmitt buffers
// Overview of operation
// - fourth port has eight pins with schmitt trigger inputs
// - each fourth port pin has its own direction bit
// - data register reads return pin levels, one bit per pin
// - direction bit one tri-states pin, zero drives it
// - fourth direction top bits read one in crystal oscillator modes
// - display lines go straight to the display module, which owns drive
// - third port pins 0 to 2 are io or display bias inputs
// - third port pin 3 is io or segment output six
// - pin 4 is io, timer gate, serial data out or segment
// - pin 5 is io, timer clock, capture/compare/pwm or segment
// - pin 6 is io, async tx, sync clock, spi clock, i2c clock, segment
// - pin 7 is io, async rx, sync data, spi data in, i2c data, segment
// - data latch kept on warm reset; direction all ones on every reset
// - segment enables cleared only by power-on or brown-out reset
// - written data latch appears on pins selected as output
//
// Local design decision: register access over AXI4-Lite.
`default_nettype none
module bpm_ports
	import bpm_pkg::*;
(
	input wire logic REF_CLK_I,
	input wire logic SYS_RST_I,
	input wire logic POR_RST_I,
	input wire logic [31:0] S_AXI_AWADDR_I,
	input wire logic S_AXI_AWVALID_I,
	output logic S_AXI_AWREADY_O,
	input wire logic [31:0] S_AXI_WDATA_I,
	input wire logic [3:0] S_AXI_WSTRB_I,
	input wire logic S_AXI_WVALID_I,
	output logic S_AXI_WREADY_O,
	output logic [1:0] S_AXI_BRESP_O,
	output logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	input wire logic [31:0] S_AXI_ARADDR_I,
	input wire logic S_AXI_ARVALID_I,
	output logic S_AXI_ARREADY_O,
	output logic [31:0] S_AXI_RDATA_O,
	output logic [1:0] S_AXI_RRESP_O,
	output logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I,
	input wire logic [7:0] THIRD_PORT_PIN_I,
	output logic [7:0] THIRD_PORT_PIN_O,
	output logic [7:0] THIRD_PORT_PIN_OE_N_O,
	input wire logic [7:0] FOURTH_PORT_PIN_I,
	output logic [7:0] FOURTH_PORT_PIN_O,
	output logic [7:0] FOURTH_PORT_PIN_OE_N_O,
	input wire logic [7:0] DISP_THIRD_DRIVE_I,
	input wire logic [7:0] DISP_THIRD_EN_I,
	input wire logic [7:0] DISP_FOURTH_DRIVE_I,
	input wire logic [7:0] DISP_FOURTH_EN_I,
	input wire logic SERIAL_DATA_OUT_I,
	input wire logic CAPTURE_COMPARE_PWM_ONE_I,
	input wire logic CCP_DRIVES_I,
	input wire logic SER_CLK_OUT_I,
	input wire logic SER_CLK_OE_N_I,
	input wire logic SER_DATA_OUT_I,
	input wire logic SER_DATA_OE_N_I,
	output logic TIMER_ONE_GATE_INPUT_O,
	output logic TIMER_ONE_CLOCK_INPUT_O,
	output logic CAPTURE_IN_O,
	output logic SER_CLK_IN_O,
	output logic SER_DATA_IN_O,
	output logic [7:0] SEGMENT_ENABLE_LOW_O,
	output logic [7:0] SEGMENT_ENABLE_MID_O,
	output logic [2:0] BIAS_INPUT_EN_O
);

	// register index from a byte address, decoded for both channels
	function automatic logic [9:0] reg_index(input logic [31:0] addr);
		reg_index = addr[11:2];
	endfunction

	// byte lane 0 merge, registers are at most 8 bits wide
	function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		lane0 = strb[0] ? d[7:0] : old;
	endfunction

	logic [7:0] third_port_data_ff, nxt_third_port_data;
	logic [7:0] fourth_port_data_ff, nxt_fourth_port_data;
	logic [7:0] third_port_direction_ff, nxt_third_port_direction;
	logic [7:0] fourth_port_direction_ff, nxt_fourth_port_direction;
	logic [7:0] segment_enable_low_ff, nxt_segment_enable_low;
	logic [7:0] segment_enable_mid_ff, nxt_segment_enable_mid;
	logic [7:0] periph_ctrl_ff, nxt_periph_ctrl;
	logic [1:0] osc_mode_ff, nxt_osc_mode;
	logic [2:0] bias_ctrl_ff, nxt_bias_ctrl;
	logic [7:0] third_in_ff, fourth_in_ff;
	bpm_state_t state_ff, nxt_state;
	logic aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got;
	logic [31:0] awaddr_ff, nxt_awaddr, wdata_ff, nxt_wdata;
	logic [3:0] wstrb_ff, nxt_wstrb;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [1:0] resp_ff, nxt_resp;
	logic [7:0] pin3_o, pin3_oe_n, pin4_o, pin4_oe_n;
	logic fourth_top_forced;
	logic [9:0] widx, ridx;
	logic do_write, do_read, wr_hit, rd_hit;
	logic [31:0] rd_val;
	logic aw_ready_ff, w_ready_ff, ar_ready_ff;

	assign fourth_top_forced = (osc_mode_ff == OSC_CRYSTAL) || (osc_mode_ff == OSC_HIGH_SPEED) ||
		(osc_mode_ff == OSC_LOW_POWER);

	assign widx = reg_index(awaddr_ff);
	assign ridx = reg_index(S_AXI_ARADDR_I);
	assign do_write = (state_ff == BPM_IDLE) && aw_got_ff && w_got_ff;
	// a read goes in only at the edge where the master sees arready high
	assign do_read = (state_ff == BPM_IDLE) && S_AXI_ARVALID_I && ar_ready_ff;

	// read mux; unmapped indices answer slverr with zero data
	always_comb begin
		rd_hit = 1'b1;
		rd_val = 32'h0000_0000;
		case (ridx)
			IDX_THIRD_DATA: rd_val[7:0] = third_in_ff;
			IDX_FOURTH_DATA: rd_val[7:0] = fourth_in_ff;
			IDX_THIRD_DIR: rd_val[7:0] = third_port_direction_ff;
			IDX_FOURTH_DIR: rd_val[7:0] = fourth_port_direction_ff |
				{fourth_top_forced, fourth_top_forced, 6'h00};
			IDX_SEG_LOW: rd_val[7:0] = segment_enable_low_ff;
			IDX_SEG_MID: rd_val[7:0] = segment_enable_mid_ff;
			IDX_PERIPH_CTRL: rd_val[7:0] = periph_ctrl_ff;
			IDX_OSC_MODE: rd_val[1:0] = osc_mode_ff;
			IDX_BIAS_CTRL: rd_val[2:0] = bias_ctrl_ff;
			default: rd_hit = 1'b0;
		endcase
	end

	// bus handshake; address and data are taken in either order
	always_comb begin
		nxt_state = state_ff;
		nxt_aw_got = aw_got_ff;
		nxt_w_got = w_got_ff;
		nxt_awaddr = awaddr_ff;
		nxt_wdata = wdata_ff;
		nxt_wstrb = wstrb_ff;
		nxt_rdata = rdata_ff;
		nxt_resp = resp_ff;
		wr_hit = 1'b1;
		if (S_AXI_AWVALID_I && aw_ready_ff && !aw_got_ff && state_ff == BPM_IDLE) begin
			nxt_aw_got = 1'b1;
			nxt_awaddr = S_AXI_AWADDR_I;
		end
		if (S_AXI_WVALID_I && w_ready_ff && !w_got_ff && state_ff == BPM_IDLE) begin
			nxt_w_got = 1'b1;
			nxt_wdata = S_AXI_WDATA_I;
			nxt_wstrb = S_AXI_WSTRB_I;
		end
		case (widx)
			IDX_THIRD_DATA, IDX_FOURTH_DATA, IDX_THIRD_DIR, IDX_FOURTH_DIR, IDX_SEG_LOW,
			IDX_SEG_MID, IDX_PERIPH_CTRL, IDX_OSC_MODE, IDX_BIAS_CTRL: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
		case (state_ff)
			BPM_IDLE: begin
				if (do_write) begin
					nxt_aw_got = 1'b0;
					nxt_w_got = 1'b0;
					nxt_resp = wr_hit ? RESP_OKAY : RESP_SLVERR;
					nxt_state = BPM_WRESP;
				end else if (do_read) begin
					nxt_rdata = rd_val;
					nxt_resp = rd_hit ? RESP_OKAY : RESP_SLVERR;
					nxt_state = BPM_RRESP;
				end
			end
			BPM_WRESP: if (S_AXI_BREADY_I) nxt_state = BPM_IDLE;
			BPM_RRESP: if (S_AXI_RREADY_I) nxt_state = BPM_IDLE;
			default: nxt_state = BPM_IDLE;
		endcase
	end

	// register writes
	always_comb begin
		nxt_third_port_data = third_port_data_ff;
		nxt_fourth_port_data = fourth_port_data_ff;
		nxt_third_port_direction = third_port_direction_ff;
		nxt_fourth_port_direction = fourth_port_direction_ff;
		nxt_segment_enable_low = segment_enable_low_ff;
		nxt_segment_enable_mid = segment_enable_mid_ff;
		nxt_periph_ctrl = periph_ctrl_ff;
		nxt_osc_mode = osc_mode_ff;
		nxt_bias_ctrl = bias_ctrl_ff;
		if (do_write) begin
			case (widx)
				IDX_THIRD_DATA: nxt_third_port_data = lane0(third_port_data_ff, wdata_ff, wstrb_ff);
				IDX_FOURTH_DATA: nxt_fourth_port_data = lane0(fourth_port_data_ff, wdata_ff,
					wstrb_ff);
				IDX_THIRD_DIR: nxt_third_port_direction = lane0(third_port_direction_ff, wdata_ff,
					wstrb_ff);
				IDX_FOURTH_DIR: nxt_fourth_port_direction = lane0(fourth_port_direction_ff,
					wdata_ff, wstrb_ff);
				IDX_SEG_LOW: nxt_segment_enable_low = lane0(segment_enable_low_ff, wdata_ff,
					wstrb_ff);
				IDX_SEG_MID: nxt_segment_enable_mid = lane0(segment_enable_mid_ff, wdata_ff,
					wstrb_ff);
				IDX_PERIPH_CTRL: nxt_periph_ctrl = lane0(periph_ctrl_ff, wdata_ff, wstrb_ff);
				IDX_OSC_MODE: if (wstrb_ff[0]) nxt_osc_mode = wdata_ff[1:0];
				IDX_BIAS_CTRL: if (wstrb_ff[0]) nxt_bias_ctrl = wdata_ff[2:0];
				default: nxt_osc_mode = osc_mode_ff;
			endcase
		end
	end

	// third port pin mux: display wins, then peripherals, then the io latch
	always_comb begin
		pin3_o = third_port_data_ff;
		pin3_oe_n = third_port_direction_ff;
		// bias pins go quiet when used as bias inputs
		for (int i = 0; i < 3; i++) begin
			if (bias_ctrl_ff[i]) pin3_oe_n[i] = 1'b1;
		end
		if (periph_ctrl_ff[PC_SPI_DO]) begin
			pin3_o[4] = SERIAL_DATA_OUT_I;
			pin3_oe_n[4] = 1'b0;
		end
		if (periph_ctrl_ff[PC_CCP] && CCP_DRIVES_I) begin
			pin3_o[5] = CAPTURE_COMPARE_PWM_ONE_I;
			pin3_oe_n[5] = 1'b0;
		end
		if (periph_ctrl_ff[PC_SERIAL]) begin
			pin3_o[6] = SER_CLK_OUT_I;
			pin3_oe_n[6] = SER_CLK_OE_N_I;
			pin3_o[7] = SER_DATA_OUT_I;
			pin3_oe_n[7] = SER_DATA_OE_N_I | ~periph_ctrl_ff[PC_SER_DATA_OUT];
		end
		for (int i = 0; i < 8; i++) begin
			if (DISP_THIRD_EN_I[i]) begin
				pin3_o[i] = DISP_THIRD_DRIVE_I[i];
				pin3_oe_n[i] = 1'b0;
			end
		end
		pin4_o = fourth_port_data_ff;
		pin4_oe_n = fourth_port_direction_ff;
		for (int i = 0; i < 8; i++) begin
			if (DISP_FOURTH_EN_I[i]) begin
				pin4_o[i] = DISP_FOURTH_DRIVE_I[i];
				pin4_oe_n[i] = 1'b0;
			end
		end
	end

	// warm-reset-surviving state: data latches, segment enables
	// latch kept
	always_ff @(posedge REF_CLK_I) begin
		if (POR_RST_I) begin
			third_port_data_ff <= DATA_RESET;
			fourth_port_data_ff <= DATA_RESET;
			segment_enable_low_ff <= SEG_RESET;
			segment_enable_mid_ff <= SEG_RESET;
			SEGMENT_ENABLE_LOW_O <= SEG_RESET;
			SEGMENT_ENABLE_MID_O <= SEG_RESET;
		end else if (!SYS_RST_I) begin
			third_port_data_ff <= nxt_third_port_data;
			fourth_port_data_ff <= nxt_fourth_port_data;
			segment_enable_low_ff <= nxt_segment_enable_low;
			segment_enable_mid_ff <= nxt_segment_enable_mid;
			// copies live here so a warm reset cannot clear them
			SEGMENT_ENABLE_LOW_O <= segment_enable_low_ff;
			SEGMENT_ENABLE_MID_O <= segment_enable_mid_ff;
		end
	end

	// everything else, reset by any reset
	always_ff @(posedge REF_CLK_I) begin
		if (SYS_RST_I || POR_RST_I) begin
			third_port_direction_ff <= DIR_RESET;
			fourth_port_direction_ff <= DIR_RESET;
			periph_ctrl_ff <= CTRL_RESET;
			osc_mode_ff <= OSC_RESET;
			bias_ctrl_ff <= 3'h0;
			state_ff <= BPM_IDLE;
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			awaddr_ff <= 32'h0000_0000;
			wdata_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
			rdata_ff <= 32'h0000_0000;
			resp_ff <= RESP_OKAY;
			third_in_ff <= 8'h00;
			fourth_in_ff <= 8'h00;
			THIRD_PORT_PIN_O <= 8'h00;
			THIRD_PORT_PIN_OE_N_O <= 8'hff;
			FOURTH_PORT_PIN_O <= 8'h00;
			FOURTH_PORT_PIN_OE_N_O <= 8'hff;
		end else begin
			third_port_direction_ff <= nxt_third_port_direction;
			fourth_port_direction_ff <= nxt_fourth_port_direction;
			periph_ctrl_ff <= nxt_periph_ctrl;
			osc_mode_ff <= nxt_osc_mode;
			bias_ctrl_ff <= nxt_bias_ctrl;
			state_ff <= nxt_state;
			aw_got_ff <= nxt_aw_got;
			w_got_ff <= nxt_w_got;
			awaddr_ff <= nxt_awaddr;
			wdata_ff <= nxt_wdata;
			wstrb_ff <= nxt_wstrb;
			rdata_ff <= nxt_rdata;
			resp_ff <= nxt_resp;
			third_in_ff <= THIRD_PORT_PIN_I;
			fourth_in_ff <= FOURTH_PORT_PIN_I;
			THIRD_PORT_PIN_O <= pin3_o;
			THIRD_PORT_PIN_OE_N_O <= pin3_oe_n;
			FOURTH_PORT_PIN_O <= pin4_o;
			FOURTH_PORT_PIN_OE_N_O <= pin4_oe_n;
		end
	end

	// bus outputs straight from flops
	assign S_AXI_AWREADY_O = aw_ready_ff;
	assign S_AXI_WREADY_O = w_ready_ff;
	assign S_AXI_ARREADY_O = ar_ready_ff;
	assign S_AXI_BVALID_O = (state_ff == BPM_WRESP);
	assign S_AXI_RVALID_O = (state_ff == BPM_RRESP);
	assign S_AXI_BRESP_O = resp_ff;
	assign S_AXI_RRESP_O = resp_ff;
	assign S_AXI_RDATA_O = rdata_ff;

	// ready flops: high while the matching slot is free in idle
	always_ff @(posedge REF_CLK_I) begin
		if (SYS_RST_I || POR_RST_I) begin
			aw_ready_ff <= 1'b0;
			w_ready_ff <= 1'b0;
			ar_ready_ff <= 1'b0;
		end else begin
			aw_ready_ff <= (nxt_state == BPM_IDLE) && !nxt_aw_got && !(S_AXI_AWVALID_I && aw_ready_ff);
			w_ready_ff <= (nxt_state == BPM_IDLE) && !nxt_w_got && !(S_AXI_WVALID_I && w_ready_ff);
			// reads wait while a write is half taken, so a read never overtakes it
			ar_ready_ff <= (nxt_state == BPM_IDLE) && !nxt_aw_got && !nxt_w_got &&
				!(S_AXI_ARVALID_I && ar_ready_ff);
		end
	end

	// peripheral inputs follow the sampled pin levels while claimed, else zero; bias enables copy the bias register
	always_ff @(posedge REF_CLK_I) begin
		if (SYS_RST_I || POR_RST_I) begin
			TIMER_ONE_GATE_INPUT_O <= 1'b0;
			TIMER_ONE_CLOCK_INPUT_O <= 1'b0;
			CAPTURE_IN_O <= 1'b0;
			SER_CLK_IN_O <= 1'b0;
			SER_DATA_IN_O <= 1'b0;
			BIAS_INPUT_EN_O <= 3'h0;
		end else begin
			TIMER_ONE_GATE_INPUT_O <= third_in_ff[4] & periph_ctrl_ff[PC_TMR_GATE];
			TIMER_ONE_CLOCK_INPUT_O <= third_in_ff[5] & periph_ctrl_ff[PC_TMR_CLK];
			CAPTURE_IN_O <= third_in_ff[5] & periph_ctrl_ff[PC_CCP];
			SER_CLK_IN_O <= third_in_ff[6] & periph_ctrl_ff[PC_SERIAL];
			SER_DATA_IN_O <= third_in_ff[7] & periph_ctrl_ff[PC_SERIAL];
			BIAS_INPUT_EN_O <= bias_ctrl_ff;
		end
	end

endmodule // bpm_ports
`default_nettype wire

/* File: tb/bpm_sva.sv */
// checker for the dual port block: bus handshakes and reset values
// assumes it is bound to bpm_ports and sees only its ports
`default_nettype none
module bpm_sva (
	input wire logic REF_CLK_I,
	input wire logic SYS_RST_I,
	input wire logic POR_RST_I,
	input wire logic S_AXI_AWVALID_I,
	input wire logic S_AXI_AWREADY_O,
	input wire logic S_AXI_WVALID_I,
	input wire logic S_AXI_WREADY_O,
	input wire logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	input wire logic S_AXI_ARVALID_I,
	input wire logic S_AXI_ARREADY_O,
	input wire logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I,
	input wire logic [7:0] FOURTH_PORT_PIN_OE_N_O,
	input wire logic [7:0] DISP_FOURTH_EN_I,
	input wire logic [7:0] SEGMENT_ENABLE_LOW_O,
	input wire logic [7:0] SEGMENT_ENABLE_MID_O
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (SYS_RST_I || POR_RST_I);
	// a write counts once both halves go in at one edge
	sequence wr_taken;
		S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
	endsequence
	sequence rd_taken;
		S_AXI_ARVALID_I && S_AXI_ARREADY_O;
	endsequence
	chk_dir_reset: assert property (disable iff (1'b0)
		((SYS_RST_I || POR_RST_I) && DISP_FOURTH_EN_I == 8'h00)[*2]
		|=> FOURTH_PORT_PIN_OE_N_O == 8'hff) else $error("pins driven after reset");
	chk_seg_por: assert property (disable iff (1'b0) POR_RST_I[*2] |=>
		SEGMENT_ENABLE_LOW_O == 8'h00 && SEGMENT_ENABLE_MID_O == 8'h00)
		else $error("segment enables not cleared");
	// kept by warm reset; two edges let the copies settle first
	chk_seg_warm: assert property (disable iff (POR_RST_I) SYS_RST_I[*3] |->
		$stable(SEGMENT_ENABLE_LOW_O) && $stable(SEGMENT_ENABLE_MID_O))
		else $error("segment enables lost on warm reset");
	chk_b_after_wr: assert property (wr_taken |-> ##[1:2] S_AXI_BVALID_O)
		else $error("write not answered");
	chk_b_hold: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O)
		else $error("write response dropped");
	chk_ar_accept: assert property ($rose(S_AXI_ARVALID_I) |-> ##[0:16] S_AXI_ARREADY_O)
		else $error("read address never taken");
	chk_r_after_ar: assert property (rd_taken |-> ##[1:4] S_AXI_RVALID_O)
		else $error("read not answered");
	chk_r_hold: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O)
		else $error("read data dropped");
endmodule // bpm_sva
bind bpm_ports bpm_sva bpm_sva_i (.REF_CLK_I(REF_CLK_I), .SYS_RST_I(SYS_RST_I),
	.POR_RST_I(POR_RST_I), .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
	.S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O),
	.S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I),
	.S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
	.S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I),
	.FOURTH_PORT_PIN_OE_N_O(FOURTH_PORT_PIN_OE_N_O), .DISP_FOURTH_EN_I(DISP_FOURTH_EN_I),
	.SEGMENT_ENABLE_LOW_O(SEGMENT_ENABLE_LOW_O), .SEGMENT_ENABLE_MID_O(SEGMENT_ENABLE_MID_O));
`default_nettype wire

/* File: tb/bpm_board.sv */
// board model: external drivers on all sixteen pins
// assumes the chip releases a pin by raising its active-low enable
`default_nettype none
module bpm_board (
	input wire logic [15:0] drv_i,
	input wire logic [15:0] oe_n_i,
	input wire logic [15:0] ext_i,
	output logic [15:0] lvl_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// board drives only released pins, so contention is not modelled
	assign lvl_o = (oe_n_i & ext_i) | (~oe_n_i & drv_i);
endmodule // bpm_board
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the dual port block over axi4-lite
// assumes the board model on the pins and the bound checker
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
	$display("FAIL %0t got %h exp %h", $time, a, e); end end
module tb
	import bpm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, srst, prst, awv, wv, bready, arv, rready, awready, wready, bvalid, arready, rvalid;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic [1:0] bresp, rresp;
	logic [7:0] c_o, c_oe, d_o, d_oe, c_ext, d_ext, den, dd_c, dd_d, v, d, b, sl, sm;
	logic [15:0] lvl;
	// lfsr seed 49668
	logic [15:0] rnd = 16'hc204;
	logic [6:0] per, per_q;
	logic tg, tc, cap, sci, serial_data_in;
	logic [2:0] bias;
	logic [9:0] e;
	logic [9:0] expq[$];
	logic [1:0] bq[$];
	int fail_count, checks_done, i;
	bpm_ports bpm_ports_i (.REF_CLK_I(clk), .SYS_RST_I(srst), .POR_RST_I(prst),
		.S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awready),
		.S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'h1), .S_AXI_WVALID_I(wv),
		.S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
		.S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv),
		.S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
		.S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .THIRD_PORT_PIN_I(lvl[7:0]),
		.THIRD_PORT_PIN_O(c_o), .THIRD_PORT_PIN_OE_N_O(c_oe), .FOURTH_PORT_PIN_I(lvl[15:8]),
		.FOURTH_PORT_PIN_O(d_o), .FOURTH_PORT_PIN_OE_N_O(d_oe), .DISP_THIRD_DRIVE_I(dd_c),
		.DISP_THIRD_EN_I(den), .DISP_FOURTH_DRIVE_I(dd_d), .DISP_FOURTH_EN_I(den),
		.SERIAL_DATA_OUT_I(per[0]), .CAPTURE_COMPARE_PWM_ONE_I(per[1]), .CCP_DRIVES_I(per[2]),
		.SER_CLK_OUT_I(per[3]), .SER_CLK_OE_N_I(per[4]), .SER_DATA_OUT_I(per[5]),
		.SER_DATA_OE_N_I(per[6]), .TIMER_ONE_GATE_INPUT_O(tg), .TIMER_ONE_CLOCK_INPUT_O(tc),
		.CAPTURE_IN_O(cap), .SER_CLK_IN_O(sci), .SER_DATA_IN_O(serial_data_in), .SEGMENT_ENABLE_LOW_O(sl),
		.SEGMENT_ENABLE_MID_O(sm), .BIAS_INPUT_EN_O(bias));
	bpm_board bpm_board_i (.drv_i({d_o, c_o}), .oe_n_i({d_oe, c_oe}), .ext_i({d_ext, c_ext}),
		.lvl_o(lvl));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// noise on peripheral outputs; unclaimed pins must ignore it
	always @(posedge clk) begin
		rnd <= lfsr(rnd);
		per <= rnd[6:0];
		// pins show peripheral values one edge late, so keep last cycle's copy
		per_q <= per;
		dd_c <= rnd[15:8];
		dd_d <= rnd[7:0];
	end
	// write one register; the request stays up until each half is taken
	task automatic wr(input logic [9:0] idx, input logic [7:0] dat, input logic [1:0] er);
		int n;
		@(posedge clk);
		bq.push_back(er);
		awaddr <= {20'h0, idx, 2'b00};
		wdata <= {24'h0, dat};
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (awv && awready) awv <= 1'b0;
			if (wv && wready) wv <= 1'b0;
		end while (!bvalid && n < 64);
		bready <= 1'b0;
		// a lost answer leaves the request up; the next call replaces it
		if (n >= 64) begin
			fail_count++;
			void'(bq.pop_back());
		end
	endtask
	// read one register; the expectation is queued for the monitor
	task automatic rd(input logic [9:0] idx, input logic [7:0] dat, input logic [1:0] er);
		int n;
		@(posedge clk);
		expq.push_back({er, dat});
		araddr <= {20'h0, idx, 2'b00};
		arv <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (arv && arready) arv <= 1'b0;
		end while (!rvalid && n < 64);
		rready <= 1'b0;
		if (n >= 64) begin
			fail_count++;
			void'(expq.pop_back());
		end
	endtask
	// data of refused reads is undefined, so only the code is compared
	always @(posedge clk) begin
		if (rvalid && rready) begin
			e = expq.pop_front();
			`CHK(rresp, e[9:8])
			if (e[9:8] == RESP_OKAY) `CHK(rdata[7:0], e[7:0])
		end
		if (bvalid && bready) begin
			e = {bq.pop_front(), 8'h00};
			`CHK(bresp, e[9:8])
		end
	end
	task automatic pulse(input logic por);
		@(posedge clk);
		if (por) prst <= 1'b1;
		else srst <= 1'b1;
		repeat (3) @(posedge clk);
		prst <= 1'b0;
		srst <= 1'b0;
		@(posedge clk);
	endtask
	task automatic final_report;
		$display("mismatches %0d checks %0d", fail_count, checks_done);
		if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (10000) @(posedge clk);
		fail_count++;
		final_report();
	end
	initial begin
		{srst, prst, awv, wv, bready, arv, rready} = 7'h60;
		{awaddr, wdata, araddr} = '0;
		{c_ext, d_ext, den} = '0;
		fail_count = 0;
		checks_done = 0;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		prst <= 1'b0;
		rd(IDX_THIRD_DIR, 8'hff, RESP_OKAY);
		rd(IDX_FOURTH_DIR, 8'hff, RESP_OKAY);
		rd(IDX_SEG_LOW, 8'h00, RESP_OKAY);
		rd(IDX_SEG_MID, 8'h00, RESP_OKAY);
		// random latch, direction and board levels
		for (i = 0; i < 6; i++) begin
			v = rnd[7:0];
			d = rnd[15:8];
			@(posedge clk);
			b = rnd[7:0];
			c_ext <= b;
			d_ext <= ~b;
			wr(IDX_FOURTH_DATA, v, RESP_OKAY);
			wr(IDX_FOURTH_DIR, d, RESP_OKAY);
			wr(IDX_THIRD_DATA, v, RESP_OKAY);
			wr(IDX_THIRD_DIR, d, RESP_OKAY);
			repeat (4) @(posedge clk);
			`CHK(d_oe, d)
			`CHK(c_oe, d)
			rd(IDX_FOURTH_DATA, (v & ~d) | (~b & d), RESP_OKAY);
			rd(IDX_THIRD_DATA, (v & ~d) | (b & d), RESP_OKAY);
		end
		// every oscillator mode; crystal modes pin the top direction bits
		wr(IDX_FOURTH_DIR, 8'h00, RESP_OKAY);
		for (i = 3; i >= 0; i--) begin
			wr(IDX_OSC_MODE, 8'(i), RESP_OKAY);
			rd(IDX_FOURTH_DIR, (i == 0) ? 8'h00 : 8'hc0, RESP_OKAY);
		end
		// bias enables and timer inputs taken from pins 4 and 5
		wr(IDX_BIAS_CTRL, 8'h05, RESP_OKAY);
		wr(IDX_THIRD_DIR, 8'hff, RESP_OKAY);
		wr(IDX_PERIPH_CTRL, 8'h03, RESP_OKAY);
		c_ext <= 8'h10;
		repeat (4) @(posedge clk);
		`CHK(bias, 3'h5)
		`CHK({tc, tg}, 2'b01)
		c_ext <= 8'hb0;
		repeat (4) @(posedge clk);
		`CHK({serial_data_in, sci, cap, tc, tg}, 5'b00011)
		// claimed pins follow the serial side instead of the io latch
		wr(IDX_PERIPH_CTRL, 8'h34, RESP_OKAY);
		repeat (4) @(posedge clk);
		`CHK({c_oe[7:6], c_oe[4]}, {per_q[6], per_q[4], 1'b0})
		`CHK({c_o[7:6], c_o[4]}, {per_q[5], per_q[3], per_q[0]})
		wr(IDX_PERIPH_CTRL, 8'h00, RESP_OKAY);
		// display ownership drives a pin whatever its direction bit says
		wr(IDX_FOURTH_DIR, 8'hff, RESP_OKAY);
		den <= 8'h08;
		repeat (3) @(posedge clk);
		`CHK({c_oe[3], d_oe[3]}, 2'b00)
		den <= 8'h00;
		// warm reset keeps latches and segment enables
		wr(IDX_SEG_LOW, 8'h3c, RESP_OKAY);
		wr(IDX_SEG_MID, 8'hc3, RESP_OKAY);
		wr(IDX_FOURTH_DATA, 8'h5a, RESP_OKAY);
		pulse(1'b0);
		rd(IDX_FOURTH_DIR, 8'hff, RESP_OKAY);
		rd(IDX_SEG_LOW, 8'h3c, RESP_OKAY);
		rd(IDX_SEG_MID, 8'hc3, RESP_OKAY);
		`CHK({sm, sl}, 16'hc33c)
		wr(IDX_FOURTH_DIR, 8'h00, RESP_OKAY);
		rd(IDX_FOURTH_DATA, 8'h5a, RESP_OKAY);
		pulse(1'b1);
		rd(IDX_SEG_LOW, SEG_RESET, RESP_OKAY);
		`CHK({sm, sl}, 16'h0000)
		wr(IDX_FOURTH_DIR, 8'h00, RESP_OKAY);
		rd(IDX_FOURTH_DATA, DATA_RESET, RESP_OKAY);
		// unmapped place is refused both ways
		wr(10'h3ff, 8'hff, RESP_SLVERR);
		rd(10'h3ff, 8'h00, RESP_SLVERR);
		repeat (4) @(posedge clk);
		final_report();
	end
endmodule // tb
`default_nettype wire
